// ===== verilog/smo_defs.svh
/*
  smo_defs.svh: offsets, field positions, reset values and analog
  code scales for the supply monitor and crystal oscillator registers.
  Assumes inclusion by bare name from the verilog/ folder.
*/
`ifndef SMO_DEFS_SVH
`define SMO_DEFS_SVH

// ****************************************************************
// register indices and byte addresses
// ****************************************************************
`define SMO_IDX_SUPPLY      12'h151
`define SMO_IDX_OSC         12'h152
`define SMO_ADDR_SUPPLY     12'h544
`define SMO_ADDR_OSC        12'h548

// ****************************************************************
// field positions
// ****************************************************************
`define SMO_BIT_PENDING     7
`define SMO_BIT_IRQ_EN      6
`define SMO_BIT_ABOVE       5
`define SMO_BIT_RANGE       4
`define SMO_MODE_MSB        7
`define SMO_MODE_LSB        4
`define SMO_CODE_MSB        3
`define SMO_CODE_LSB        0

// ****************************************************************
// reset values and special codes
// ****************************************************************
`define SMO_RST_MODE        4'hF
`define SMO_MODE_EXT_REF    4'h4
`define SMO_RST_CODE        4'h0

// ****************************************************************
// analog scales, millivolts and tenths of a picofarad
// ****************************************************************
`define SMO_HI_BASE_MV      2550
`define SMO_HI_STEP_MV      75
`define SMO_HI_TOP_MV       3675
`define SMO_LO_BASE_MV      1700
`define SMO_LO_STEP_MV      50
`define SMO_LO_TOP_MV       2450
`define SMO_TRIM_STEP_DPF   3
`define SMO_TRIM_TOP_DPF    45

`endif

// ===== verilog/smo_pkg.sv
/*
  smo_pkg: types shared by the supply monitor and oscillator registers.
  Assumes smo_defs.svh for the numeric constants.
*/
package smo_pkg;

  typedef logic [3:0]  smo_code_t;
  typedef logic [11:0] smo_addr_t;
  typedef logic [31:0] smo_word_t;

  // complete state of the register block
  typedef struct packed {
    logic      pending;
    logic      irq_en;
    logic      above;
    logic      range;
    smo_code_t thresh;
    smo_code_t mode;
    smo_code_t trim;
    logic      ext_ref;
    logic      irq;
    logic      pready;
    logic      pslverr;
    smo_word_t prdata;
  } smo_state_t;

endpackage : smo_pkg

// ===== verilog/smo_regs.sv
/*
  smo_regs: APB slave holding the supply monitor control/status
  register and the crystal oscillator control register, driving the
  codes to the comparator and oscillator and raising one interrupt.
  Assumes all inputs synchronous to clock_in and an APB master that
  holds its request until pready is seen high.
*/
// Function
// - pending flag bit 7, cleared by writing one
// - enable bit 6 gates the interrupt request
// - read-only status bit 5: supply above threshold
// - status follows current threshold and range
// - bit 4 picks low or high range
// - 4-bit linear threshold code in bits 3:0
// - oscillator mode bits 7:4, reset 0xF
// - mode 0x4 selects external reference
// - trim code bits 3:0 to load arrays
`timescale 1ns/1ps
`include "smo_defs.svh"

module smo_regs (
  input  wire logic               clock_in,
  input  wire logic               rstn_in,
  input  wire logic               psel_in,
  input  wire logic               penable_in,
  input  wire logic               pwrite_in,
  input  wire smo_pkg::smo_addr_t paddr_in,
  input  wire smo_pkg::smo_word_t pwdata_in,
  input  wire logic [3:0]         pstrb_in,
  input  wire logic               supply_above_in,
  output logic                    pready_out,
  output logic                    pslverr_out,
  output smo_pkg::smo_word_t      prdata_out,
  output smo_pkg::smo_code_t      threshold_code_out,
  output logic                    range_select_out,
  output smo_pkg::smo_code_t      osc_mode_out,
  output logic                    osc_ext_ref_out,
  output smo_pkg::smo_code_t      osc_load_trim_out,
  output logic                    irq_out
);
  import smo_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  smo_state_t q;
  smo_state_t d;

  logic access;
  logic hit_supply;
  logic hit_osc;
  logic wr_supply;
  logic wr_osc;
  logic supply_fell;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    d           = q;
    access      = psel_in & penable_in;
    hit_supply  = (paddr_in == `SMO_ADDR_SUPPLY);
    hit_osc     = (paddr_in == `SMO_ADDR_OSC);
    // writes land at the edge where pready is sampled high
    wr_supply   = access & q.pready & pwrite_in & hit_supply & pstrb_in[0];
    wr_osc      = access & q.pready & pwrite_in & hit_osc & pstrb_in[0];
    supply_fell = q.above & ~supply_above_in;

    // one wait state: pready rises on the second access cycle
    d.pready  = access & ~q.pready;
    d.pslverr = access & ~q.pready & ~(hit_supply | hit_osc);

    if (access && !q.pready) begin
      d.prdata = '0;
      if (hit_supply) begin
        d.prdata[`SMO_BIT_PENDING] = q.pending;
        d.prdata[`SMO_BIT_IRQ_EN]  = q.irq_en;
        d.prdata[`SMO_BIT_ABOVE]   = q.above;
        d.prdata[`SMO_BIT_RANGE]   = q.range;
        d.prdata[`SMO_CODE_MSB:`SMO_CODE_LSB] = q.thresh;
      end else if (hit_osc) begin
        d.prdata[`SMO_MODE_MSB:`SMO_MODE_LSB] = q.mode;
        d.prdata[`SMO_CODE_MSB:`SMO_CODE_LSB] = q.trim;
      end
    end

    // status bit comes only from the comparator
    d.above = supply_above_in;

    if (wr_supply) begin
      d.irq_en = pwdata_in[`SMO_BIT_IRQ_EN];
      d.range  = pwdata_in[`SMO_BIT_RANGE];
      d.thresh = pwdata_in[`SMO_CODE_MSB:`SMO_CODE_LSB];
    end
    if (wr_osc) begin
      d.mode = pwdata_in[`SMO_MODE_MSB:`SMO_MODE_LSB];
      d.trim = pwdata_in[`SMO_CODE_MSB:`SMO_CODE_LSB];
    end

    // a fall in the clearing cycle keeps the flag set
    if (supply_fell) begin
      d.pending = 1'b1;
    end else if (wr_supply && pwdata_in[`SMO_BIT_PENDING]) begin
      d.pending = 1'b0;
    end

    d.ext_ref = (d.mode == `SMO_MODE_EXT_REF);
    d.irq     = d.pending & d.irq_en;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock_in) begin
    if (!rstn_in) begin
      q         <= '0;
      q.mode    <= `SMO_RST_MODE;
      q.thresh  <= `SMO_RST_CODE;
      q.trim    <= `SMO_RST_CODE;
    end else begin
      q <= d;
    end
  end

  assign pready_out         = q.pready;
  assign pslverr_out        = q.pslverr;
  assign prdata_out         = q.prdata;
  assign threshold_code_out = q.thresh;
  assign range_select_out   = q.range;
  assign osc_mode_out       = q.mode;
  assign osc_ext_ref_out    = q.ext_ref;
  assign osc_load_trim_out  = q.trim;
  assign irq_out            = q.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  // the analog side sees these figures for the driven codes
  int unsigned thr_mv;
  int unsigned trim_dpf;
  always_comb begin
    thr_mv   = q.range ? (`SMO_HI_BASE_MV + `SMO_HI_STEP_MV * int'(q.thresh))
                       : (`SMO_LO_BASE_MV + `SMO_LO_STEP_MV * int'(q.thresh));
    trim_dpf = `SMO_TRIM_STEP_DPF * int'(q.trim);
  end

  // ****************************************************************
  // checker helpers
  // ****************************************************************
  // bus events decoded from the pins, so the checks do not lean on
  // the decode that they are meant to judge
  logic bus_acc;
  logic sup_wr_seen;
  logic sup_clr_seen;
  logic osc_wr_seen;
  logic nostrb_wr_seen;
  logic unmapped_seen;

  assign bus_acc        = psel_in & penable_in;
  assign sup_wr_seen    = bus_acc & pready_out & pwrite_in & pstrb_in[0] & (paddr_in == `SMO_ADDR_SUPPLY);
  assign sup_clr_seen   = sup_wr_seen & pwdata_in[`SMO_BIT_PENDING];
  assign osc_wr_seen    = bus_acc & pready_out & pwrite_in & pstrb_in[0] & (paddr_in == `SMO_ADDR_OSC);
  assign nostrb_wr_seen = bus_acc & pready_out & pwrite_in & ~pstrb_in[0];
  assign unmapped_seen  = (paddr_in != `SMO_ADDR_SUPPLY) & (paddr_in != `SMO_ADDR_OSC);

  sequence acc_first_s;
    psel_in && penable_in && !pready_out;
  endsequence

  sequence supply_write_s;
    psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0]
      && paddr_in == `SMO_ADDR_SUPPLY;
  endsequence

  sequence osc_write_s;
    psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0]
      && paddr_in == `SMO_ADDR_OSC;
  endsequence

  sequence supply_read_s;
    acc_first_s ##0 (!pwrite_in && paddr_in == `SMO_ADDR_SUPPLY);
  endsequence

  sequence osc_read_s;
    acc_first_s ##0 (!pwrite_in && paddr_in == `SMO_ADDR_OSC);
  endsequence

  sequence unmapped_s;
    acc_first_s ##0 unmapped_seen;
  endsequence

  sequence clash_s;
    supply_write_s ##0 (pwdata_in[`SMO_BIT_PENDING] && q.above && !supply_above_in);
  endsequence

  apb_ready_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    acc_first_s |=> pready_out ##1 !pready_out)
    else $error("pready not one cycle after access start");

  pend_clear_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (supply_write_s ##0 (pwdata_in[7] && supply_above_in)) |=> !q.pending)
    else $error("pending not cleared by write of one");

  pend_set_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (q.above && !supply_above_in) |=> q.pending ##1 (q.pending || irq_out == 1'b0))
    else $error("pending not set on supply fall");

  irq_gate_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    irq_out |-> (q.pending && q.irq_en))
    else $error("interrupt raised without pending and enable");

  irq_raise_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (q.pending && q.irq_en) |-> irq_out)
    else $error("interrupt missing while pending and enabled");

  status_rd_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    supply_read_s |=> prdata_out[5] == $past(supply_above_in, 2))
    else $error("status bit does not show comparator");

  thr_drive_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    supply_write_s |=> (threshold_code_out == $past(pwdata_in[3:0])
                        && range_select_out == $past(pwdata_in[4])
                        && q.above == $past(supply_above_in)))
    else $error("threshold or range not driven after write");

  thr_span_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    range_select_out |-> (thr_mv >= `SMO_HI_BASE_MV && thr_mv <= `SMO_HI_TOP_MV))
    else $error("high range threshold out of span");

  lo_span_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !range_select_out |-> (thr_mv >= `SMO_LO_BASE_MV && thr_mv <= `SMO_LO_TOP_MV))
    else $error("low range threshold out of span");

  mode_reset_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !$past(rstn_in) |-> (osc_mode_out == 4'hF && osc_load_trim_out == 4'h0))
    else $error("oscillator mode not 0xF after reset");

  ext_ref_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    osc_ext_ref_out == (osc_mode_out == 4'h4))
    else $error("external reference select wrong for mode");

  trim_drive_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    osc_write_s |=> (osc_load_trim_out == $past(pwdata_in[3:0])
                     && trim_dpf <= `SMO_TRIM_TOP_DPF))
    else $error("trim code not driven after write");

  pend_hold_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (supply_write_s ##0 (!pwdata_in[7] && !(q.above && !supply_above_in)))
      |=> q.pending == $past(q.pending))
    else $error("pending changed by write of zero");

  pend_sticky_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (q.pending && !sup_clr_seen) |=> q.pending)
    else $error("pending flag dropped without a clear");

  clear_cause_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $fell(q.pending) |-> $past(sup_clr_seen))
    else $error("pending cleared without a write of one");

  // a fall and a clear in one cycle must leave the flag set
  set_wins_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    clash_s |=> q.pending)
    else $error("clear overrode a supply fall in the same cycle");

  set_cause_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(q.pending) |-> ($past(supply_above_in, 2) && !$past(supply_above_in)))
    else $error("pending set without a supply fall");

  mode_drive_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    osc_write_s |=> osc_mode_out == $past(pwdata_in[7:4]))
    else $error("oscillator mode not driven after write");

  ext_sel_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (osc_write_s ##0 pwdata_in[7:4] == 4'h4) |=> osc_ext_ref_out)
    else $error("mode 0x4 did not select the external reference");

  osc_read_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    osc_read_s |=> (prdata_out[7:4] == $past(osc_mode_out) && prdata_out[3:0] == $past(osc_load_trim_out)
                    && prdata_out[31:8] == 24'h000000))
    else $error("oscillator register read back wrong");

  strobe_off_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    nostrb_wr_seen |=> (osc_mode_out == $past(osc_mode_out) && osc_load_trim_out == $past(osc_load_trim_out)
                        && threshold_code_out == $past(threshold_code_out)))
    else $error("write without lane 0 strobe changed a register");

  unmapped_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    unmapped_s |=> (pready_out && pslverr_out && prdata_out == 32'h00000000))
    else $error("unmapped access not refused");

  ready_cause_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    pready_out |-> $past(bus_acc))
    else $error("pready raised without an access");

  supply_read_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    supply_read_s |=> (prdata_out[3:0] == $past(threshold_code_out) && prdata_out[4] == $past(range_select_out)
                       && prdata_out[31:8] == 24'h000000))
    else $error("supply register read back wrong");

  osc_apart_a: assert property (@(posedge clock_in) disable iff (!rstn_in)
    osc_write_s |=> (threshold_code_out == $past(threshold_code_out)
                     && range_select_out == $past(range_select_out)))
    else $error("oscillator write disturbed the supply fields");

endmodule : smo_regs

// ===== testbench/tb_top.sv
/*
  tb_top: self-checking bench for the supply monitor and oscillator
  register block, driven over APB with the comparator input in hand.
  Assumes smo_pkg compiled first and smo_defs.svh on the include path.
*/
`timescale 1ns/1ps
`include "smo_defs.svh"

module tb_top;
  import smo_pkg::*;

  // ************************************************************
  // signals and design
  // ************************************************************
  logic       clock_in = 1'b0;
  logic       rstn_in = 1'b0;
  logic       psel_in = 1'b0;
  logic       penable_in = 1'b0;
  logic       pwrite_in = 1'b0;
  smo_addr_t  paddr_in = 12'h000;
  smo_word_t  pwdata_in = 32'h0;
  logic [3:0] pstrb_in = 4'hF;
  logic       supply_above_in = 1'b1;
  logic       pready_out, pslverr_out, range_select_out, osc_ext_ref_out, irq_out;
  smo_word_t  prdata_out;
  smo_code_t  threshold_code_out, osc_mode_out, osc_load_trim_out;
  int         fails = 0;
  int         check_count = 0;
  smo_word_t  rd;
  logic       er;

  smo_regs u_dut (.clock_in(clock_in), .rstn_in(rstn_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
    .supply_above_in(supply_above_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .prdata_out(prdata_out), .threshold_code_out(threshold_code_out), .range_select_out(range_select_out),
    .osc_mode_out(osc_mode_out), .osc_ext_ref_out(osc_ext_ref_out), .osc_load_trim_out(osc_load_trim_out),
    .irq_out(irq_out));

  initial begin
    forever #25 clock_in = ~clock_in;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task conclude;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // one idle cycle before setup keeps back-to-back calls from double driving psel
  task apb(input logic wr, input smo_addr_t a, input smo_word_t d);
    int n;
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      conclude();
    end
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(negedge clock_in);
  endtask : apb

  task rdchk(input string name, input smo_addr_t a, input smo_word_t exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask : rdchk

  // ************************************************************
  // scenarios
  // ************************************************************
  task t_reset;
    chk("mode", 32'(osc_mode_out), 32'h0000000F);
    chk("ext", 32'(osc_ext_ref_out), 32'h0);
    chk("irq", 32'(irq_out), 32'h0);
    rdchk("supply", `SMO_ADDR_SUPPLY, 32'h00000020);
    rdchk("osc", `SMO_ADDR_OSC, 32'h000000F0);
    $display("reset test done");
  endtask : t_reset

  task t_fields;
    apb(1'b1, `SMO_ADDR_SUPPLY, 32'h000000FF);
    rdchk("supply", `SMO_ADDR_SUPPLY, 32'h0000007F);
    chk("thr", 32'(threshold_code_out), 32'h0000000F);
    chk("range", 32'(range_select_out), 32'h1);
    apb(1'b1, `SMO_ADDR_SUPPLY, 32'h00000003);
    chk("thr", 32'(threshold_code_out), 32'h00000003);
    rdchk("supply", `SMO_ADDR_SUPPLY, 32'h00000023);
    chk("range", 32'(range_select_out), 32'h0);
    $display("field test done");
  endtask : t_fields

  task t_irq;
    apb(1'b1, `SMO_ADDR_SUPPLY, 32'h00000053);
    chk("irq", 32'(irq_out), 32'h0);
    @(posedge clock_in);
    supply_above_in <= 1'b0;
    repeat (3) @(negedge clock_in);
    chk("irq", 32'(irq_out), 32'h1);
    rdchk("supply", `SMO_ADDR_SUPPLY, 32'h000000D3);
    apb(1'b1, `SMO_ADDR_SUPPLY, 32'h00000013);
    chk("irq", 32'(irq_out), 32'h0);
    rdchk("supply", `SMO_ADDR_SUPPLY, 32'h00000093);
    apb(1'b1, `SMO_ADDR_SUPPLY, 32'h00000093);
    rdchk("supply", `SMO_ADDR_SUPPLY, 32'h00000013);
    apb(1'b1, `SMO_ADDR_SUPPLY, 32'h00000053);
    chk("irq", 32'(irq_out), 32'h0);
    @(posedge clock_in);
    supply_above_in <= 1'b1;
    $display("interrupt test done");
  endtask : t_irq

  task t_osc;
    apb(1'b1, `SMO_ADDR_OSC, 32'h0000004A);
    chk("mode", 32'(osc_mode_out), 32'h00000004);
    chk("ext", 32'(osc_ext_ref_out), 32'h1);
    chk("trim", 32'(osc_load_trim_out), 32'h0000000A);
    rdchk("osc", `SMO_ADDR_OSC, 32'h0000004A);
    apb(1'b1, `SMO_ADDR_OSC, 32'h000000FF);
    chk("ext", 32'(osc_ext_ref_out), 32'h0);
    chk("trim", 32'(osc_load_trim_out), 32'h0000000F);
    $display("oscillator test done");
  endtask : t_osc

  task t_refuse;
    apb(1'b1, 12'h54C, 32'h00000000);
    chk("err", 32'(er), 32'h1);
    apb(1'b0, 12'h54C, 32'h0);
    chk("err", 32'(er), 32'h1);
    chk("data", rd, 32'h0);
    @(posedge clock_in);
    pstrb_in <= 4'h0;
    apb(1'b1, `SMO_ADDR_OSC, 32'h00000011);
    @(posedge clock_in);
    pstrb_in <= 4'hF;
    rdchk("osc", `SMO_ADDR_OSC, 32'h000000FF);
    $display("refusal test done");
  endtask : t_refuse

  task t_midreset;
    apb(1'b1, `SMO_ADDR_OSC, 32'h0000004A);
    @(posedge clock_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(negedge clock_in);
    chk("mode", 32'(osc_mode_out), 32'h0000000F);
    chk("ext", 32'(osc_ext_ref_out), 32'h0);
    chk("trim", 32'(osc_load_trim_out), 32'h0);
    chk("thr", 32'(threshold_code_out), 32'h0);
    chk("range", 32'(range_select_out), 32'h0);
    chk("irq", 32'(irq_out), 32'h0);
    rdchk("supply", `SMO_ADDR_SUPPLY, 32'h00000020);
    $display("mid-run reset test done");
  endtask : t_midreset

  initial begin
    repeat (3) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(negedge clock_in);
    t_reset();
    t_fields();
    t_irq();
    t_osc();
    t_refuse();
    t_midreset();
    conclude();
  end
endmodule : tb_top
